/* File: src/esr_consts.vh */
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define ESR_IDX_INSPECT     12'h28F
`define ESR_IDX_LEVEL       12'h292
`define ESR_IDX_FF_EN       12'h2A2
`define ESR_IDX_FF_LIM      12'h2A5
`define ESR_IDX_PRIO        12'h2A7
`define ESR_IDX_MAXFREQ     12'h303
`define ESR_IDX_CTRL        12'h3F0
`define ESR_IDX_STATUS      12'h3F1
`define ESR_IDX_REF_OUT     12'h3F2
`define ESR_IDX_FN_MAP      12'h3F3
`define ESR_IDX_FN_MAP2     12'h3F4
// Reset values and limits, units of 0.01 Hz or 0.01 % or 1 %
`define ESR_RST_INSPECT     16'h09C4
`define ESR_RST_LEVEL       16'h0190
`define ESR_RST_FF_EN       16'h0000
`define ESR_RST_FF_LIM      16'h0190
`define ESR_RST_PRIO        16'h0000
`define ESR_RST_MAXFREQ     16'h1770
`define ESR_RST_NOMINAL     16'h1388
`define ESR_PCT_MAX         16'h2710
`define ESR_FF_LIM_MIN      16'h0064
`define ESR_FF_LIM_MAX      16'h0190
`define ESR_PRIO_MAX        16'h0002
// Speed selection codes for speed_src_out
`define ESR_SRC_NONE        3'h0
`define ESR_SRC_MULTI       3'h1
`define ESR_SRC_INSPECT     3'h2
`define ESR_SRC_LEVEL       3'h3
`define ESR_SRC_JOG         3'h4
`define ESR_SRC_HIGH        3'h5
// Multi-function input codes per mode
`define ESR_FN_P_1          8'h80
`define ESR_FN_P_2          8'h84
`define ESR_FN_P_3          8'h81
`define ESR_FN_P_4          8'h83
`define ESR_FN_P_5          8'h0F
`define ESR_FN_M_1          8'h24
`define ESR_FN_M_2          8'h14
`define ESR_FN_M_3          8'h03
`define ESR_FN_M_4          8'h04
`define ESR_FN_M_5          8'h06
`endif

/* File: src/esr_speed_ref_select.v */
// Overview of operation
// (R1) Inspection command selects the inspection speed register, default 25.00 Hz.
// (R2) Leveling command selects the leveling speed register, default 4.00 Hz.
// (R3) Priority field takes 0 to 2, default 0, choosing the reference set.
// (R4) Priority 1 or 2 hides multi-step set and remaps inputs to its codes.
// (R5) Priority 0 hides nominal/intermediate/releveling and remaps inputs to its codes.
// (R6) Priority 0 turns the leveling register into the jog reference.
// (R7) Inspection and leveling values are capped at maximum output frequency.
// (R8) In permanent magnet vector mode references range 0.00 to 100.00 percent.
// (R9) Leveling reference applies only via nominal/intermediate/releveling command decode.
// (R10) Inspection reference applies only when an inspection input is assigned.
// (R11) Field forcing enable takes 0 or 1, default 0; active only at 1.
// (R12) Field forcing current is clamped to limit, range 100 to 400, default 400.
// (R13) Limit of 100 percent equals motor no-load current.
// (R14) Field forcing applies in all states except DC injection braking.
// (R15) Priority and field forcing writes are refused while the drive runs.
//
// Design decision made here: register access over AXI4-Lite.
`include "esr_consts.vh"
`default_nettype none
module esr_speed_ref_select #(
	parameter AW = 14
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [AW-1:0] s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire          inspection_speed_cmd,
	input  wire          leveling_speed_cmd,
	input  wire          nominal_speed_cmd,
	input  wire          intermediate_speed_cmd,
	input  wire          releveling_speed_cmd,
	input  wire [2:0]    multi_step_sel,
	input  wire          drive_running,
	input  wire          dc_injection,
	input  wire          pm_vector_mode,
	input  wire [15:0]   no_load_current,
	input  wire [15:0]   field_current_demand,
	output reg  [15:0]   speed_ref_out,
	output reg  [2:0]    speed_src_out,
	output reg           jog_active,
	output reg  [15:0]   field_current_out,
	output reg           field_force_active,
	output reg           multi_step_visible,
	output reg           elevator_set_visible
);

	// ****************************************
	// Registers
	// ****************************************
	reg  [15:0] inspection_speed_ref_reg;
	reg  [15:0] leveling_speed_ref_reg;
	reg  [15:0] nominal_speed_ref_reg;
	reg  [15:0] multi_step_ref_reg;
	reg  [15:0] field_force_enable_reg;
	reg  [15:0] field_force_limit_reg;
	reg  [15:0] speed_priority_select_reg;
	reg  [15:0] max_output_frequency_reg;
	reg  [1:0]  ctrl_reg;
	reg         refused_reg;
	reg  [AW-1:0] awaddr_reg;
	reg  [31:0] wdata_reg;
	reg         aw_held_reg;
	reg         w_held_reg;

	// ****************************************
	// Write channel
	// ****************************************
	wire [11:0] widx = awaddr_reg[13:2];
	wire [15:0] wval = wdata_reg[15:0];
	wire        do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire        locked = drive_running;
	wire [15:0] ref_cap = pm_vector_mode ? `ESR_PCT_MAX : max_output_frequency_reg;
	wire [15:0] ref_wr;
	wire [15:0] lim_wr;
	reg         wr_ok;
	reg         wr_locked;

	esr_clamp #(
		.W(16)
	) esr_clamp_ref_i (
		.val(wval),
		.lo (16'h0000),
		.hi (ref_cap),
		.out(ref_wr)
	); // R7 R8

	esr_clamp #(
		.W(16)
	) esr_clamp_lim_i (
		.val(wval),
		.lo (`ESR_FF_LIM_MIN),
		.hi (`ESR_FF_LIM_MAX),
		.out(lim_wr)
	); // R12

	always @* begin
		wr_ok = 1'b1;
		wr_locked = 1'b0;
		case (widx)
			`ESR_IDX_INSPECT, `ESR_IDX_LEVEL, `ESR_IDX_MAXFREQ, `ESR_IDX_CTRL,
			`ESR_IDX_STATUS, `ESR_IDX_REF_OUT, `ESR_IDX_FN_MAP, `ESR_IDX_FN_MAP2: begin
				wr_ok = 1'b1;
			end
			`ESR_IDX_FF_EN, `ESR_IDX_FF_LIM, `ESR_IDX_PRIO: begin
				wr_locked = locked; // R15
			end
			default: begin
				wr_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= {AW{1'b0}};
			wdata_reg <= 32'h00000000;
			inspection_speed_ref_reg <= `ESR_RST_INSPECT; // R1
			leveling_speed_ref_reg <= `ESR_RST_LEVEL; // R2
			nominal_speed_ref_reg <= `ESR_RST_NOMINAL;
			multi_step_ref_reg <= 16'h0000;
			field_force_enable_reg <= `ESR_RST_FF_EN; // R11
			field_force_limit_reg <= `ESR_RST_FF_LIM; // R12
			speed_priority_select_reg <= `ESR_RST_PRIO; // R3
			max_output_frequency_reg <= `ESR_RST_MAXFREQ;
			ctrl_reg <= 2'h0;
			refused_reg <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (!wr_ok || wr_locked) ? 2'h2 : 2'h0;
				refused_reg <= wr_locked; // R15
				if (wr_ok && !wr_locked) begin
					case (widx)
						`ESR_IDX_INSPECT: inspection_speed_ref_reg <= ref_wr; // R1 R7
						`ESR_IDX_LEVEL: leveling_speed_ref_reg <= ref_wr; // R2 R7
						`ESR_IDX_MAXFREQ: max_output_frequency_reg <= wval;
						`ESR_IDX_FF_EN: field_force_enable_reg <= {15'h0000, wval[0]}; // R11
						`ESR_IDX_FF_LIM: field_force_limit_reg <= lim_wr; // R12
						`ESR_IDX_PRIO: begin
							if (wval <= `ESR_PRIO_MAX) begin
								speed_priority_select_reg <= wval; // R3
							end
						end
						`ESR_IDX_CTRL: ctrl_reg <= wval[1:0];
						`ESR_IDX_FN_MAP: begin
							if (multi_step_visible) begin
								multi_step_ref_reg <= ref_wr; // R4
							end
							if (elevator_set_visible) begin
								nominal_speed_ref_reg <= ref_wr; // R5
							end
						end
						default: begin
							refused_reg <= refused_reg;
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	wire [11:0] ridx = s_axi_araddr[13:2];
	reg  [31:0] rd_val;
	reg         rd_ok;
	wire        prio0 = (speed_priority_select_reg == 16'h0000);
	wire [39:0] fn_map = prio0 ?
		{`ESR_FN_M_5, `ESR_FN_M_4, `ESR_FN_M_3, `ESR_FN_M_2, `ESR_FN_M_1} :
		{`ESR_FN_P_5, `ESR_FN_P_4, `ESR_FN_P_3, `ESR_FN_P_2, `ESR_FN_P_1}; // R4 R5

	always @* begin
		rd_ok = 1'b1;
		rd_val = 32'h00000000;
		case (ridx)
			`ESR_IDX_INSPECT: rd_val = {16'h0000, inspection_speed_ref_reg};
			`ESR_IDX_LEVEL: rd_val = {16'h0000, leveling_speed_ref_reg};
			`ESR_IDX_FF_EN: rd_val = {16'h0000, field_force_enable_reg};
			`ESR_IDX_FF_LIM: rd_val = {16'h0000, field_force_limit_reg};
			`ESR_IDX_PRIO: rd_val = {16'h0000, speed_priority_select_reg};
			`ESR_IDX_MAXFREQ: rd_val = {16'h0000, max_output_frequency_reg};
			`ESR_IDX_CTRL: rd_val = {30'h00000000, ctrl_reg};
			`ESR_IDX_STATUS: rd_val = {24'h000000, refused_reg, jog_active,
				field_force_active, multi_step_visible, elevator_set_visible,
				speed_src_out};
			`ESR_IDX_REF_OUT: rd_val = {field_current_out, speed_ref_out};
			`ESR_IDX_FN_MAP: rd_val = fn_map[31:0];
			`ESR_IDX_FN_MAP2: rd_val = {24'h000000, fn_map[39:32]};
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Speed selection
	// ****************************************
	// ctrl_reg[0]: inspection function assigned; ctrl_reg[1] is stored and
	// read back but drives no selection logic
	wire        insp_assigned = ctrl_reg[0];
	wire        lvl_decode = leveling_speed_cmd && !intermediate_speed_cmd &&
		!releveling_speed_cmd; // R9
	reg  [2:0]  src_next;
	reg  [15:0] ref_next;

	always @* begin
		src_next = `ESR_SRC_NONE;
		ref_next = 16'h0000;
		if (insp_assigned && inspection_speed_cmd) begin
			src_next = `ESR_SRC_INSPECT; // R1 R10
			ref_next = inspection_speed_ref_reg;
		end else if (prio0) begin
			if (leveling_speed_cmd) begin
				src_next = `ESR_SRC_JOG; // R6
				ref_next = leveling_speed_ref_reg;
			end else if (multi_step_sel != 3'h0) begin
				src_next = `ESR_SRC_MULTI; // R3 R5
				ref_next = multi_step_ref_reg;
			end
		end else if (speed_priority_select_reg == 16'h0002 && lvl_decode) begin
			src_next = `ESR_SRC_LEVEL; // R2 R3 R9
			ref_next = leveling_speed_ref_reg;
		end else if (nominal_speed_cmd) begin
			src_next = `ESR_SRC_HIGH; // R3
			ref_next = nominal_speed_ref_reg;
		end else if (lvl_decode) begin
			src_next = `ESR_SRC_LEVEL; // R2 R9
			ref_next = leveling_speed_ref_reg;
		end
	end

	// ****************************************
	// Field forcing
	// ****************************************
	wire [31:0] ff_prod = no_load_current * field_force_limit_reg;
	wire [31:0] ff_quot = ff_prod / 32'h00000064;
	wire [15:0] ff_ceiling = (ff_quot > 32'h0000FFFF) ? 16'hFFFF : ff_quot[15:0]; // R13
	wire        ff_on = field_force_enable_reg[0] && !dc_injection; // R11 R14
	wire [15:0] ff_hi = ff_on ? ff_ceiling : 16'hFFFF;
	wire [15:0] ff_clamped;

	esr_clamp #(
		.W(16)
	) esr_clamp_ff_i (
		.val(field_current_demand),
		.lo (16'h0000),
		.hi (ff_hi),
		.out(ff_clamped)
	); // R12

	always @(posedge aclk) begin
		if (!aresetn) begin
			speed_ref_out <= 16'h0000;
			speed_src_out <= `ESR_SRC_NONE;
			jog_active <= 1'b0;
			field_current_out <= 16'h0000;
			field_force_active <= 1'b0;
			multi_step_visible <= 1'b1;
			elevator_set_visible <= 1'b0;
		end else begin
			speed_ref_out <= ref_next;
			speed_src_out <= src_next;
			jog_active <= (src_next == `ESR_SRC_JOG);
			field_force_active <= ff_on;
			field_current_out <= ff_clamped; // R12
			multi_step_visible <= prio0; // R4
			elevator_set_visible <= !prio0; // R5
		end
	end

endmodule

// ****************************************
// Saturating clamp
// ****************************************
module esr_clamp #(
	parameter W = 16
) (
	input  wire [W-1:0] val,
	input  wire [W-1:0] lo,
	input  wire [W-1:0] hi,
	output wire [W-1:0] out
);

	assign out = (val < lo) ? lo : (val > hi) ? hi : val;

endmodule
`default_nettype wire

/* File: tb/esr_chk.sv */
`include "esr_consts.vh"
`default_nettype none
// ************************************************
// Output relations at the block's ports
// ************************************************
module esr_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        dc_injection,
	input wire logic        inspection_speed_cmd,
	input wire logic [15:0] no_load_current,
	input wire logic [15:0] field_current_demand,
	input wire logic [15:0] field_current_out,
	input wire logic [2:0]  speed_src_out,
	input wire logic        jog_active,
	input wire logic        field_force_active,
	input wire logic        multi_step_visible,
	input wire logic        elevator_set_visible
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_vis; multi_step_visible != elevator_set_visible; endproperty
	a_vis: assert property (p_vis) else $error("visibility flags clash");
	property p_jog;
		jog_active |-> multi_step_visible && speed_src_out == `ESR_SRC_JOG;
	endproperty
	a_jog: assert property (p_jog) else $error("jog outside mode 0");
	property p_lvl; speed_src_out == `ESR_SRC_LEVEL |-> elevator_set_visible; endproperty
	a_lvl: assert property (p_lvl) else $error("leveling used in mode 0");
	property p_multi; speed_src_out == `ESR_SRC_MULTI |-> multi_step_visible; endproperty
	a_multi: assert property (p_multi) else $error("hidden multi-step used");
	property p_high; speed_src_out == `ESR_SRC_HIGH |-> elevator_set_visible; endproperty
	a_high: assert property (p_high) else $error("hidden high speed used");
	property p_insp; speed_src_out == `ESR_SRC_INSPECT |-> $past(inspection_speed_cmd); endproperty
	a_insp: assert property (p_insp) else $error("inspection without command");
	property p_dc; dc_injection |=> !field_force_active; endproperty
	a_dc: assert property (p_dc) else $error("forcing during dc braking");
	property p_lim;
		field_force_active |-> field_current_out <= $past(field_current_demand)
			&& {2'b00, field_current_out} <= {$past(no_load_current), 2'b00};
	endproperty
	a_lim: assert property (p_lim) else $error("field current above ceiling");
endmodule
bind esr_speed_ref_select esr_chk esr_chk_i (.*);
`default_nettype wire

/* File: tb/esr_lift_ctrl.sv */
`default_nettype none
// ************************************************
// Contact inputs from the lift controller
// ************************************************
module esr_lift_ctrl (
	input  wire logic       aclk,
	input  wire logic [4:0] cmd,
	output var  logic       inspection_speed_cmd,
	output var  logic       leveling_speed_cmd,
	output var  logic       nominal_speed_cmd,
	output var  logic       intermediate_speed_cmd,
	output var  logic       releveling_speed_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge aclk) begin
		{releveling_speed_cmd, intermediate_speed_cmd, nominal_speed_cmd,
			leveling_speed_cmd, inspection_speed_cmd} <= cmd;
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`include "esr_consts.vh"
`default_nettype none
// ************************************************
// Bench
// ************************************************
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, drive_running, dc_injection, pm_vector_mode, jog_active;
	logic        field_force_active, multi_step_visible, elevator_set_visible;
	logic        inspection_speed_cmd, leveling_speed_cmd, nominal_speed_cmd;
	logic        intermediate_speed_cmd, releveling_speed_cmd;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  multi_step_sel, speed_src_out;
	logic [15:0] no_load_current, field_current_demand, speed_ref_out, field_current_out;
	logic [4:0]  cmd;
	int          failures, comparisons, cycles;
	logic [11:0] ridx [5] = '{`ESR_IDX_INSPECT, `ESR_IDX_LEVEL, `ESR_IDX_FF_EN,
		`ESR_IDX_FF_LIM, `ESR_IDX_PRIO};
	logic [15:0] rval [5] = '{16'h09C4, 16'h0190, 16'h0000, 16'h0190, 16'h0000};
	esr_speed_ref_select esr_speed_ref_select_i (.*);
	esr_lift_ctrl        esr_lift_ctrl_i (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t bus got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t output got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk_bus({s_axi_bresp, 32'h0}, {er, 32'h0});
	endtask
	task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk_bus({s_axi_rresp, s_axi_rdata}, {er, exp});
	endtask
	// Drive contacts and status, then let both register stages land
	task automatic go(input logic [4:0] c, input logic r, input logic d, input logic p);
		@(posedge aclk);
		cmd <= c;
		drive_running <= r;
		dc_injection <= d;
		pm_vector_mode <= p;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, drive_running, dc_injection, pm_vector_mode} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd, multi_step_sel} = '0;
		{failures, comparisons, cycles} = '0;
		s_axi_wstrb = 4'hF;
		no_load_current = 16'h03E8;
		field_current_demand = 16'h1388;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(ridx[i], {16'h0000, rval[i]}, 2'h0);
		rd(12'h100, 32'h0, 2'h2);
		rd(`ESR_IDX_FN_MAP, 32'h04031424, 2'h0);
		rd(`ESR_IDX_FN_MAP2, 32'h00000006, 2'h0);
		$display("test reset done");
		go(5'h01, 1'b0, 1'b0, 1'b0);
		chk_out({13'h0, speed_src_out}, {13'h0, `ESR_SRC_NONE});
		wr(`ESR_IDX_CTRL, 16'h0001, 2'h0);
		go(5'h01, 1'b0, 1'b0, 1'b0);
		chk_out({13'h0, speed_src_out}, {13'h0, `ESR_SRC_INSPECT});
		chk_out(speed_ref_out, 16'h09C4);
		go(5'h02, 1'b0, 1'b0, 1'b0);
		chk_out({12'h0, speed_src_out, jog_active}, {12'h0, `ESR_SRC_JOG, 1'b1});
		chk_out(speed_ref_out, 16'h0190);
		$display("test mode zero done");
		wr(`ESR_IDX_PRIO, 16'h0002, 2'h0);
		wr(`ESR_IDX_PRIO, 16'h0003, 2'h0);
		rd(`ESR_IDX_PRIO, 32'h2, 2'h0);
		rd(`ESR_IDX_FN_MAP, 32'h83818480, 2'h0);
		rd(`ESR_IDX_FN_MAP2, 32'h0000000F, 2'h0);
		go(5'h06, 1'b0, 1'b0, 1'b0);
		chk_out({13'h0, speed_src_out}, {13'h0, `ESR_SRC_LEVEL});
		chk_out(speed_ref_out, 16'h0190);
		chk_out({14'h0, elevator_set_visible, multi_step_visible}, 16'h0002);
		wr(`ESR_IDX_PRIO, 16'h0001, 2'h0);
		rd(`ESR_IDX_PRIO, 32'h1, 2'h0);
		go(5'h06, 1'b0, 1'b0, 1'b0);
		chk_out({13'h0, speed_src_out}, {13'h0, `ESR_SRC_HIGH});
		chk_out(speed_ref_out, 16'h1388);
		$display("test priority done");
		go(5'h00, 1'b1, 1'b0, 1'b0);
		wr(`ESR_IDX_PRIO, 16'h0000, 2'h2);
		wr(`ESR_IDX_FF_EN, 16'h0001, 2'h2);
		rd(`ESR_IDX_PRIO, 32'h1, 2'h0);
		rd(`ESR_IDX_STATUS, 32'h00000088, 2'h0);
		go(5'h00, 1'b0, 1'b0, 1'b0);
		wr(`ESR_IDX_PRIO, 16'h0000, 2'h0);
		wr(`ESR_IDX_FN_MAP, 16'h0BB8, 2'h0);
		multi_step_sel <= 3'h1;
		go(5'h00, 1'b0, 1'b0, 1'b0);
		chk_out({13'h0, speed_src_out}, {13'h0, `ESR_SRC_MULTI});
		chk_out(speed_ref_out, 16'h0BB8);
		rd(`ESR_IDX_STATUS, 32'h00000011, 2'h0);
		rd(`ESR_IDX_REF_OUT, 32'h13880BB8, 2'h0);
		$display("test lock done");
		wr(`ESR_IDX_FF_LIM, 16'h0032, 2'h0);
		rd(`ESR_IDX_FF_LIM, 32'h0064, 2'h0);
		wr(`ESR_IDX_FF_EN, 16'h0001, 2'h0);
		go(5'h00, 1'b0, 1'b0, 1'b0);
		chk_out(field_current_out, 16'h03E8);
		chk_out({15'h0, field_force_active}, 16'h0001);
		wr(`ESR_IDX_FF_LIM, 16'h0190, 2'h0);
		go(5'h00, 1'b0, 1'b0, 1'b0);
		chk_out(field_current_out, 16'h0FA0);
		go(5'h00, 1'b0, 1'b1, 1'b0);
		chk_out({15'h0, field_force_active}, 16'h0000);
		wr(`ESR_IDX_FF_EN, 16'h0000, 2'h0);
		go(5'h00, 1'b0, 1'b0, 1'b0);
		chk_out({15'h0, field_force_active}, 16'h0000);
		$display("test field forcing done");
		wr(`ESR_IDX_INSPECT, 16'hFFFF, 2'h0);
		rd(`ESR_IDX_INSPECT, 32'h1770, 2'h0);
		go(5'h00, 1'b0, 1'b0, 1'b1);
		wr(`ESR_IDX_LEVEL, 16'hFFFF, 2'h0);
		rd(`ESR_IDX_LEVEL, 32'h2710, 2'h0);
		$display("test clamps done");
		print_verdict();
	end
endmodule
`default_nettype wire
